// ===== rtl/bpirq_pkg.sv
package bpirq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_ENABLE_SET   = 4'h0;
    localparam logic [3:0]  ADDR_ENABLE_CLR   = 4'h4;
    localparam logic [3:0]  ADDR_PENDING      = 4'h8;
    localparam logic [3:0]  ADDR_ENABLE_READ  = 4'hC;
    localparam int          ADDR_W            = 4;
    localparam int          REG_W             = 16;
    localparam int          NUM_SRC           = 5;
    localparam logic [15:0] ENABLE_RESET      = 16'h0000;
    localparam logic [15:0] PENDING_RESET     = 16'h0000;
    localparam logic [15:0] LIVE_MASK         = 16'h001F;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    // ------------------------------------------------------------
    // Source bit positions
    // ------------------------------------------------------------
    localparam int BIT_PUSH_BUTTONS  = 0;
    localparam int BIT_SWITCH_BANK   = 1;
    localparam int BIT_FIVE_WAY      = 2;
    localparam int BIT_MODE_BUTTON   = 3;
    localparam int BIT_NETWORK_CTRL  = 4;

    // ------------------------------------------------------------
    // Input widths
    // ------------------------------------------------------------
    localparam int PB_W   = 4;
    localparam int DIP_W  = 4;
    localparam int JOY_W  = 5;

endpackage

// ===== rtl/bpirq_sync.sv
`timescale 1ns/1ps
module bpirq_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    // Two stages; first stage read only by the second
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ===== rtl/bpirq_top.sv
// Operation
// - All enabled source events merge onto one request output to the host.
// - Request signals only for flagged sources whose enable bit is set.
// - Enable write sets masked bits, disable write clears them, others unchanged.
// - New interrupt shown as falling edge on request line when no enabled flag is already pending; host queries on it.
// - Host reads flag register; device returns pending flags identifying sources.
// - Host clears handled flags with mask; masked flag bits clear unless their source flags again in the same cycle.
// - Bit 0 buttons, 1 switches, 2 stick, 3 mode button, 4 network.
// - Buttons, switches and stick flag on any change of any of their inputs; mode button flags on press only.
// - Network controller interrupt output forwarded as one flagged source.
`timescale 1ns/1ps
module bpirq_top (
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic [3:0]                  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [3:0]                  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [bpirq_pkg::PB_W-1:0]  push_buttons,
    input  wire logic [bpirq_pkg::DIP_W-1:0] switch_bank,
    input  wire logic [bpirq_pkg::JOY_W-1:0] five_way_stick,
    input  wire logic                        energy_monitor_button,
    input  wire logic                        network_ctrl_irq_b,
    output logic                             host_irq_request_pin_b
);
    localparam int IN_W = bpirq_pkg::PB_W + bpirq_pkg::DIP_W + bpirq_pkg::JOY_W + 2;

    logic [IN_W-1:0]              in_sync;
    logic [IN_W-1:0]              in_prev_reg;
    logic                         seen_reg;
    logic [bpirq_pkg::REG_W-1:0]  irq_source_enable_reg;
    logic [bpirq_pkg::REG_W-1:0]  irq_source_pending_reg;
    logic [bpirq_pkg::REG_W-1:0]  event_vec;
    logic [bpirq_pkg::REG_W-1:0]  wmask;
    logic                         aw_have_reg;
    logic                         w_have_reg;
    logic [3:0]                   aw_addr_reg;
    logic [31:0]                  w_data_reg;
    logic                         wr_fire;
    logic                         irq_reg;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    bpirq_sync #(
        .W (IN_W)
    ) u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in ({network_ctrl_irq_b, energy_monitor_button, five_way_stick,
                    switch_bank, push_buttons}),
        .sync_out (in_sync)
    );

    // First cycle after reset captures synchroniser reset zeros, so inputs high at reset still show a change
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            in_prev_reg <= '0;
            seen_reg    <= 1'b0;
        end
        else
        begin
            in_prev_reg <= in_sync;
            seen_reg    <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Source events
    // ------------------------------------------------------------
    localparam int O_DIP = bpirq_pkg::PB_W;
    localparam int O_JOY = O_DIP + bpirq_pkg::DIP_W;
    localparam int O_MOD = O_JOY + bpirq_pkg::JOY_W;
    localparam int O_NET = O_MOD + 1;

    logic [IN_W-1:0] chg;
    assign chg = seen_reg ? (in_sync ^ in_prev_reg) : '0;

    always_comb
    begin
        event_vec = '0;
        event_vec[bpirq_pkg::BIT_PUSH_BUTTONS] = |chg[O_DIP-1:0];
        event_vec[bpirq_pkg::BIT_SWITCH_BANK]  = |chg[O_JOY-1:O_DIP];
        event_vec[bpirq_pkg::BIT_FIVE_WAY]     = |chg[O_MOD-1:O_JOY];
        // Mode button flags on press only
        event_vec[bpirq_pkg::BIT_MODE_BUTTON]  = chg[O_MOD] & in_sync[O_MOD];
        // Network line is active low: flag on its falling edge
        event_vec[bpirq_pkg::BIT_NETWORK_CTRL] = chg[O_NET] & ~in_sync[O_NET];
    end

    // ------------------------------------------------------------
    // AXI4-Lite write
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
    assign wr_fire       = aw_have_reg && w_have_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            aw_addr_reg  <= '0;
            w_data_reg   <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= bpirq_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg <= 1'b1;
                w_data_reg <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                               {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}} & s_axi_wdata;
            end
            if (wr_fire)
            begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg == bpirq_pkg::ADDR_ENABLE_READ)
                                ? bpirq_pkg::RESP_SLVERR : bpirq_pkg::RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Masked-off strobes count as zeros, so a partial write leaves bits alone
    assign wmask = w_data_reg[bpirq_pkg::REG_W-1:0] & bpirq_pkg::LIVE_MASK;

    // ------------------------------------------------------------
    // Enable and pending registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            irq_source_enable_reg <= bpirq_pkg::ENABLE_RESET;
        end
        else if (wr_fire && aw_addr_reg == bpirq_pkg::ADDR_ENABLE_SET)
        begin
            irq_source_enable_reg <= irq_source_enable_reg | wmask;
        end
        else if (wr_fire && aw_addr_reg == bpirq_pkg::ADDR_ENABLE_CLR)
        begin
            irq_source_enable_reg <= irq_source_enable_reg & ~wmask;
        end
    end

    // New events win over a same-cycle clear
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            irq_source_pending_reg <= bpirq_pkg::PENDING_RESET;
        end
        else if (wr_fire && aw_addr_reg == bpirq_pkg::ADDR_PENDING)
        begin
            irq_source_pending_reg <= (irq_source_pending_reg & ~wmask) | event_vec;
        end
        else
        begin
            irq_source_pending_reg <= irq_source_pending_reg | event_vec;
        end
    end

    // ------------------------------------------------------------
    // Request line
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |(irq_source_pending_reg & irq_source_enable_reg);
        end
    end

    // Falls when first enabled flag appears
    assign host_irq_request_pin_b = ~irq_reg;

    // ------------------------------------------------------------
    // AXI4-Lite read
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= bpirq_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= bpirq_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                bpirq_pkg::ADDR_ENABLE_SET,
                bpirq_pkg::ADDR_ENABLE_CLR,
                bpirq_pkg::ADDR_ENABLE_READ:
                    s_axi_rdata <= {16'h0000, irq_source_enable_reg};
                bpirq_pkg::ADDR_PENDING:
                    s_axi_rdata <= {16'h0000, irq_source_pending_reg};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= bpirq_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_unused_bits_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (irq_source_enable_reg & ~bpirq_pkg::LIVE_MASK) == '0
        && (irq_source_pending_reg & ~bpirq_pkg::LIVE_MASK) == '0)
        else $error("unused bits set");

    a_request_follows_flags: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 (host_irq_request_pin_b == !(|$past(irq_source_pending_reg & irq_source_enable_reg))))
        else $error("request line mismatch");

    a_flag_sticks: assert property (@(posedge clk) disable iff (!rst_b)
        (irq_source_pending_reg[0] && !(wr_fire && aw_addr_reg == bpirq_pkg::ADDR_PENDING))
        |=> irq_source_pending_reg[0])
        else $error("flag dropped without clear");

    a_event_sets_flag: assert property (@(posedge clk) disable iff (!rst_b)
        event_vec[bpirq_pkg::BIT_PUSH_BUTTONS] |=> irq_source_pending_reg[0])
        else $error("event not flagged");

    a_enable_set_works: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_fire && aw_addr_reg == bpirq_pkg::ADDR_ENABLE_SET)
        |=> ((irq_source_enable_reg & $past(wmask)) == $past(wmask)))
        else $error("enable set failed");

    a_enable_clr_works: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_fire && aw_addr_reg == bpirq_pkg::ADDR_ENABLE_CLR)
        |=> ((irq_source_enable_reg & $past(wmask)) == '0))
        else $error("enable clear failed");

    a_clear_exact: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_fire && aw_addr_reg == bpirq_pkg::ADDR_PENDING)
        |=> ((irq_source_pending_reg & ~$past(wmask)) ==
             (($past(irq_source_pending_reg) | $past(event_vec)) & ~$past(wmask))))
        else $error("clear touched other bits");

    a_net_forwarded: assert property (@(posedge clk) disable iff (!rst_b)
        event_vec[bpirq_pkg::BIT_NETWORK_CTRL] |=> irq_source_pending_reg[4])
        else $error("network event lost");

    a_request_falls: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(host_irq_request_pin_b) |-> $past(|(irq_source_pending_reg & irq_source_enable_reg)))
        else $error("spurious falling edge");

endmodule

// ===== verif/bpirq_host_model.sv
`timescale 1ns/1ps
module bpirq_host_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic irq_pin_b,
    output int        edges
);
    // ----------------------------
    // Request pin watcher
    // ----------------------------
    logic level;
    logic level_reg;

    // Pull-up: a released or unknown line reads high
    assign level = (irq_pin_b === 1'b0) ? 1'b0 : 1'b1;

    // Falling edge only, so a held-low line is one request
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            level_reg <= 1'b1;
            edges     <= 0;
        end
        else
        begin
            level_reg <= level;
            if (level_reg && !level)
                edges <= edges + 1;
        end
    end
endmodule

// ===== verif/board_peripheral_irq_aggregator_tb.sv
`timescale 1ns/1ps
module board_peripheral_irq_aggregator_tb;
    // ----------------------------
    // Signals and model state
    // ----------------------------
    logic                        clk, rst_b;
    logic [3:0]                  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0]                 s_axi_wdata, s_axi_rdata;
    logic [1:0]                  s_axi_bresp, s_axi_rresp;
    logic                        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                        s_axi_rvalid, s_axi_rready;
    logic [bpirq_pkg::PB_W-1:0]  push_buttons;
    logic [bpirq_pkg::DIP_W-1:0] switch_bank;
    logic [bpirq_pkg::JOY_W-1:0] five_way_stick;
    logic                        energy_monitor_button, network_ctrl_irq_b;
    logic                        host_irq_request_pin_b, pin_exp, pin_prev;
    logic [31:0]                 seed;
    int                          failures, checks_done, edges, exp_edges, en, pend;

    bpirq_top dut_u (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .push_buttons,
        .switch_bank, .five_way_stick, .energy_monitor_button, .network_ctrl_irq_b,
        .host_irq_request_pin_b);
    bpirq_host_model host_u (.clk, .rst_b, .irq_pin_b(host_irq_request_pin_b), .edges);

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard, far above the few hundred cycles needed
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        end_of_test;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // ----------------------------
    // Checks and bus tasks
    // ----------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d,
            input logic [1:0] er = bpirq_pkg::RESP_OKAY);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk);
            aw_ok = aw_ok | (s_axi_awready === 1'b1);
            w_ok = w_ok | (s_axi_wready === 1'b1);
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [31:0] ed,
            input logic [1:0] er = bpirq_pkg::RESP_OKAY);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask

    // Event to pin low takes four edges
    task settle;
        repeat (6) @(posedge clk);
    endtask

    task chk_pin;
        pin_exp = ((pend & en) != 0) ? 1'b0 : 1'b1;
        if (pin_prev && !pin_exp)
            exp_edges++;
        pin_prev = pin_exp;
        chk(host_irq_request_pin_b, pin_exp);
        chk(edges, exp_edges);
    endtask

    // Release of mode button and network line must not flag
    task ev(input int i);
        seed = lfsr(seed);
        @(posedge clk);
        case (i)
            0: push_buttons <= push_buttons ^ (seed[3:0] | 4'h1);
            1: switch_bank <= switch_bank ^ (seed[7:4] | 4'h1);
            2: five_way_stick <= five_way_stick ^ (seed[12:8] | 5'h01);
            3: energy_monitor_button <= 1'b1;
            default: network_ctrl_irq_b <= 1'b0;
        endcase
        settle;
        energy_monitor_button <= 1'b0;
        network_ctrl_irq_b <= 1'b1;
        settle;
        pend = pend | (1 << i);
        rd(bpirq_pkg::ADDR_PENDING, pend);
        chk_pin;
    endtask

    // ----------------------------
    // Main sequence
    // ----------------------------
    initial
    begin
        {rst_b, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {push_buttons, switch_bank, five_way_stick, energy_monitor_button} = '0;
        s_axi_wstrb = 4'hF;
        network_ctrl_irq_b = 1'b1;
        seed = 32'h535007A8;
        {failures, checks_done, exp_edges, en, pend} = '0;
        pin_prev = 1'b1;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rd(bpirq_pkg::ADDR_ENABLE_READ, bpirq_pkg::ENABLE_RESET);
        rd(bpirq_pkg::ADDR_PENDING, bpirq_pkg::PENDING_RESET);
        chk_pin;
        wr(bpirq_pkg::ADDR_ENABLE_CLR, 32'h0000FFFF);
        wr(bpirq_pkg::ADDR_PENDING, 32'h0000FFFF);
        wr(bpirq_pkg::ADDR_ENABLE_SET, 32'h0000FFFF);
        en = 32'h1F;
        rd(bpirq_pkg::ADDR_ENABLE_READ, en);
        wr(bpirq_pkg::ADDR_ENABLE_CLR, 32'h00000005);
        en = 32'h1A;
        rd(bpirq_pkg::ADDR_ENABLE_SET, en);
        wr(bpirq_pkg::ADDR_ENABLE_CLR, 32'h0000FFFF);
        en = 0;
        rd(bpirq_pkg::ADDR_ENABLE_CLR, en);
        for (int i = 0; i < 5; i++)
            ev(i);
        wr(bpirq_pkg::ADDR_ENABLE_SET, 32'h00000010);
        en = 32'h10;
        settle;
        chk_pin;
        wr(bpirq_pkg::ADDR_ENABLE_SET, 32'h0000FFE0);
        rd(bpirq_pkg::ADDR_ENABLE_READ, en);
        // Lane zero off: its bits must survive a clear-all
        s_axi_wstrb <= 4'hE;
        wr(bpirq_pkg::ADDR_ENABLE_CLR, 32'h0000FFFF);
        s_axi_wstrb <= 4'hF;
        rd(bpirq_pkg::ADDR_ENABLE_READ, en);
        wr(bpirq_pkg::ADDR_PENDING, 32'h00000015);
        pend = pend & ~32'h15;
        rd(bpirq_pkg::ADDR_PENDING, pend);
        settle;
        chk_pin;
        wr(bpirq_pkg::ADDR_ENABLE_SET, 32'h00000002);
        en = 32'h12;
        settle;
        chk_pin;
        wr(bpirq_pkg::ADDR_PENDING, 32'h0000FFFF);
        pend = 0;
        settle;
        chk_pin;
        ev(1);
        wr(bpirq_pkg::ADDR_ENABLE_READ, 32'h0000FFFF, bpirq_pkg::RESP_SLVERR);
        rd(bpirq_pkg::ADDR_ENABLE_READ, en);
        rd(4'h2, 32'h00000000, bpirq_pkg::RESP_SLVERR);
        end_of_test;
    end
endmodule
